// *** rtl/sarcr_dev.sv ***
// converter end: conversion sequencing on core_clk, result shifting on the link clock
// assumes nrst models the supply monitor and that core_clk stands for the trimmed oscillator
`timescale 1ns/1ns
`default_nettype none
module sarcr_dev #(
    parameter int POR_CYC = sarcr_pkg::POR_WAIT_CYC
) (
    input  wire logic                           core_clk,   // internal conversion clock
    input  wire logic                           nrst,       // power-on reset, low active
    sarcr_link_if.dev                           link,       // pins to the controller
    input  wire logic                           chain_mode, // strap: 1 selects chain mode
    input  wire logic [sarcr_pkg::RES_BITS-1:0] analog_in,  // digital stand-in for the input
    output logic                                powered_up, // conversion logic powered
    output logic                                acquiring,  // input tracking for next sample
    output logic                                init_done   // reinitialisation over
);
    import sarcr_pkg::*;

    localparam int PW = $clog2(POR_CYC + 1);

    sarcr_dev_state_t      state_reg;
    logic [PW-1:0]         por_cnt_reg;
    logic [CONV_CW-1:0]    conv_cnt_reg;
    logic                  cnv_s1_reg;
    logic                  cnv_s2_reg;
    logic                  cnv_prev_reg;
    logic                  cnv_rise;

    logic [RES_BITS-1:0]   sample_reg;
    logic [RES_BITS-1:0]   result_reg;
    logic                  load_tgl_reg;
    logic                  busy_reg;
    logic                  acq_reg;
    logic                  conv_go;
    logic                  conv_end;
    logic                  result_msb;

    // shift clock domain
    logic                  taken_tgl_reg;
    logic [RES_BITS-1:0]   shift_reg;
    logic                  fresh;
    logic                  chain_bit;

    ////////////////////////////////////////////////////////////////////////////
    // convert_start is a pin: two flops before the edge detector
    // the third flop keeps the old level:
    // a level held high is never an edge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnv_s1_reg   <= 1'b0;
            cnv_s2_reg   <= 1'b0;
            cnv_prev_reg <= 1'b0;
        end else begin
            cnv_s1_reg   <= link.convert_start;
            cnv_s2_reg   <= cnv_s1_reg;
            cnv_prev_reg <= cnv_s2_reg;
        end
    end

    assign cnv_rise = cnv_s2_reg & ~cnv_prev_reg;

    // starts count only while powered down
    assign conv_go  = (state_reg == DEV_DOWN) & cnv_rise;
    assign conv_end = (state_reg == DEV_CONV) & (conv_cnt_reg == CONV_CW'(CONV_CYC - 1));

    ////////////////////////////////////////////////////////////////////////////
    // conversion sequencer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= DEV_INIT;
        end else begin
            unique case (state_reg)
                DEV_INIT: begin
                    // edges are dropped here, the result would be invalid
                    if (por_cnt_reg == PW'(POR_CYC - 1)) begin
                        state_reg <= DEV_DOWN;
                    end
                end
                DEV_DOWN: begin
                    // last result still readable
                    if (cnv_rise) begin
                        state_reg <= DEV_CONV;
                    end
                end
                DEV_CONV: begin
                    // no restart: cnv_rise is not looked at here
                    if (conv_cnt_reg == CONV_CW'(CONV_CYC - 1)) begin
                        state_reg <= DEV_DOWN;
                    end
                end
                default: begin
                    state_reg <= DEV_INIT;
                end
            endcase
        end
    end

    // counts in init only
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            por_cnt_reg <= '0;
        end else if (state_reg == DEV_INIT) begin
            por_cnt_reg <= por_cnt_reg + PW'(1);
        end
    end

    // always the worst-case length
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            conv_cnt_reg <= '0;
        end else if (state_reg == DEV_CONV) begin
            conv_cnt_reg <= conv_cnt_reg + CONV_CW'(1);
        end else begin
            conv_cnt_reg <= '0;
        end
    end

    // busy is registered so it changes with the state, not a cycle later
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            busy_reg <= 1'b0;
        end else if (conv_go) begin
            busy_reg <= 1'b1;
        end else if (conv_end) begin
            busy_reg <= 1'b0;
        end
    end

    // the hold capacitor goes back to tracking the input once the comparisons no longer need the held sample
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            acq_reg <= 1'b1;
        end else if (conv_go) begin
            acq_reg <= 1'b0;
        end else if (state_reg == DEV_CONV && conv_cnt_reg == CONV_CW'(ACQ_CYC - 1)) begin
            acq_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sample_reg <= '0;
        end else if (conv_go) begin
            // held as the sampling capacitor would
            sample_reg <= analog_in;
        end
    end

    // result only changes at the end of a conversion, so it is quasi-static for the link
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            result_reg   <= '0;
            load_tgl_reg <= 1'b0;
        end else if (conv_end) begin
            result_reg   <= sample_reg;
            load_tgl_reg <= ~load_tgl_reg;
        end
    end

    // powered_up and init_done decoded from the state, busy and acquiring from registers
    assign link.busy  = busy_reg;
    assign powered_up = (state_reg == DEV_CONV);
    assign acquiring  = acq_reg;
    assign init_done  = (state_reg != DEV_INIT);

    ////////////////////////////////////////////////////////////////////////////
    // link side, clocked by the shift clock
    // the shift clock stands still from conversion start until busy has fallen, so the
    // toggle and the result word are stable by the first edge; this is the handshake.
    // limitation: shifting during a conversion end may catch a half-loaded frame.
    assign fresh     = (load_tgl_reg != taken_tgl_reg);
    // an enable in normal mode
    assign chain_bit = chain_mode & link.read_enable_or_chain_in;

    always_ff @(posedge link.sck or negedge nrst) begin
        if (!nrst) begin
            taken_tgl_reg <= 1'b0;
            shift_reg     <= '0;
        end else if (fresh) begin
            taken_tgl_reg <= load_tgl_reg;
            shift_reg     <= {result_reg[RES_BITS-2:0], chain_bit};
        end else begin
            shift_reg     <= {shift_reg[RES_BITS-2:0], chain_bit};
        end
    end

    assign result_msb = result_reg[RES_BITS-1];

    // before the first edge of a readout the msb comes straight from the result
    always_comb begin
        if (fresh) begin
            link.sdo = result_msb;
        end else begin
            link.sdo = shift_reg[RES_BITS-1];
        end
    end

    always_comb begin
        if (chain_mode) begin
            link.sdo_oe_n = 1'b0;
        end else begin
            link.sdo_oe_n = link.read_enable_or_chain_in;
        end
    end

endmodule : sarcr_dev
`default_nettype wire

// *** rtl/sarcr_host.sv ***
// controller end: waits out reinitialisation, starts conversions, reads the result
// assumes one converter in normal mode, or a chain of them with READ_BITS set to match
`timescale 1ns/1ns
`default_nettype none
module sarcr_host #(
    parameter int POR_CYC   = sarcr_pkg::POR_WAIT_CYC,
    parameter int READ_BITS = sarcr_pkg::RES_BITS,
    parameter int SCK_HALF  = sarcr_pkg::SCK_HALF_CYC
) (
    input  wire logic                 core_clk,     // controller clock
    input  wire logic                 nrst,         // reset, low active
    sarcr_link_if.hst                 link,         // pins to the converter
    input  wire logic                 start,        // request one conversion and readout
    output logic                      ready,        // a start would be taken now
    output logic [READ_BITS-1:0]      result,       // last word read, msb first
    output logic                      result_valid  // one-cycle pulse with new result
);
    import sarcr_pkg::*;

    localparam int PW = $clog2(POR_CYC + 1);
    localparam int BW = $clog2(READ_BITS + 1);
    localparam int HW = $clog2(SCK_HALF + 1);
    localparam int WW = $clog2(BUSY_SETTLE + CNV_HIGH_CYC + 1);

    sarcr_hst_state_t    state_reg;
    logic [PW-1:0]       por_cnt_reg;
    logic [WW-1:0]       wait_cnt_reg;
    logic [HW-1:0]       half_cnt_reg;
    logic [BW-1:0]       bit_cnt_reg;
    logic                busy_s1_reg;
    logic                busy_s2_reg;
    logic                sdo_s1_reg;
    logic                sdo_s2_reg;
    logic                cnv_reg;
    logic                sck_reg;
    logic                rdl_reg;
    logic                valid_reg;
    logic [READ_BITS-1:0] data_reg;
    logic                half_done;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            busy_s1_reg <= 1'b0;
            busy_s2_reg <= 1'b0;
            sdo_s1_reg  <= 1'b0;
            sdo_s2_reg  <= 1'b0;
        end else begin
            busy_s1_reg <= link.busy;
            busy_s2_reg <= busy_s1_reg;
            sdo_s1_reg  <= link.sdo_line;
            sdo_s2_reg  <= sdo_s1_reg;
        end
    end

    assign half_done = (half_cnt_reg == HW'(SCK_HALF - 1));

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= HST_POR;
        end else begin
            unique case (state_reg)
                HST_POR: begin
                    if (por_cnt_reg == PW'(POR_CYC - 1)) begin
                        state_reg <= HST_IDLE;
                    end
                end
                HST_IDLE: begin
                    if (start) begin
                        state_reg <= HST_CNV;
                    end
                end
                HST_CNV: begin
                    // falls back inside the quiet window after the edge
                    if (wait_cnt_reg == WW'(CNV_HIGH_CYC - 1)) begin
                        state_reg <= HST_WAIT;
                    end
                end
                HST_WAIT: begin
                    // the settle delay covers the time busy needs to rise and be synced
                    if (wait_cnt_reg >= WW'(BUSY_SETTLE + CNV_HIGH_CYC) && !busy_s2_reg) begin
                        state_reg <= HST_SETUP;
                    end
                end
                HST_SETUP: begin
                    if (half_done) begin
                        state_reg <= HST_READ;
                    end
                end
                HST_READ: begin
                    if (half_done && sck_reg && bit_cnt_reg == BW'(READ_BITS)) begin
                        state_reg <= HST_IDLE;
                    end
                end
                default: begin
                    state_reg <= HST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            por_cnt_reg <= '0;
        end else if (state_reg == HST_POR) begin
            por_cnt_reg <= por_cnt_reg + PW'(1);
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wait_cnt_reg <= '0;
        end else if (state_reg == HST_CNV || state_reg == HST_WAIT) begin
            if (wait_cnt_reg != '1) begin
                wait_cnt_reg <= wait_cnt_reg + WW'(1);
            end
        end else begin
            wait_cnt_reg <= '0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            half_cnt_reg <= '0;
        end else if ((state_reg == HST_SETUP || state_reg == HST_READ) && !half_done) begin
            half_cnt_reg <= half_cnt_reg + HW'(1);
        end else begin
            half_cnt_reg <= '0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnv_reg <= 1'b0;
        end else begin
            cnv_reg <= (state_reg == HST_IDLE && start) || (state_reg == HST_CNV && 
                        wait_cnt_reg != WW'(CNV_HIGH_CYC - 1));
        end
    end

    // output disabled and clock parked low whenever no readout runs
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdl_reg <= 1'b1;
        end else begin
            rdl_reg <= !(state_reg == HST_WAIT && wait_cnt_reg >= 
                         WW'(BUSY_SETTLE + CNV_HIGH_CYC) && !busy_s2_reg) &&
                       !(state_reg == HST_SETUP) &&
                       !(state_reg == HST_READ && !(half_done && sck_reg &&
                         bit_cnt_reg == BW'(READ_BITS)));
        end
    end

    // a bit is taken just before each rising edge, i.e. the next rising edge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sck_reg     <= 1'b0;
            bit_cnt_reg <= '0;
            data_reg    <= '0;
        end else if (state_reg == HST_READ && half_done) begin
            if (!sck_reg) begin
                data_reg    <= {data_reg[READ_BITS-2:0], sdo_s2_reg};
                bit_cnt_reg <= bit_cnt_reg + BW'(1);
                sck_reg     <= 1'b1;
            end else begin
                sck_reg     <= 1'b0;
            end
        end else if (state_reg != HST_READ) begin
            sck_reg     <= 1'b0;
            bit_cnt_reg <= '0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            valid_reg <= 1'b0;
            result    <= '0;
        end else begin
            valid_reg <= state_reg == HST_READ && half_done && sck_reg &&
                         bit_cnt_reg == BW'(READ_BITS);
            if (state_reg == HST_READ && half_done && sck_reg &&
                bit_cnt_reg == BW'(READ_BITS)) begin
                result <= data_reg;
            end
        end
    end

    assign link.convert_start           = cnv_reg;
    assign link.sck                     = sck_reg;
    assign link.read_enable_or_chain_in = rdl_reg;
    assign ready                        = (state_reg == HST_IDLE);
    assign result_valid                 = valid_reg;

endmodule : sarcr_host
`default_nettype wire

// *** rtl/sarcr_link_if.sv ***
// pins between the converter end and its controller
// assumes the bench joins both ends here; a released sdo reads as its pull-up level
`timescale 1ns/1ns
`default_nettype none
interface sarcr_link_if;
    logic convert_start;            // start request, rising edge starts
    logic busy;                     // conversion running
    logic sck;                      // shift clock from the controller
    logic sdo;                      // serial data driven by converter
    logic sdo_oe_n;                 // low while converter drives sdo
    logic read_enable_or_chain_in;  // read enable (normal) or chain input
    wire  sdo_line;                 // resolved serial line

    assign sdo_line = sdo_oe_n ? 1'b1 : sdo;

    modport dev (
        input  convert_start, sck, read_enable_or_chain_in,
        output busy, sdo, sdo_oe_n
    );
    modport hst (
        output convert_start, sck, read_enable_or_chain_in,
        input  busy, sdo_line
    );
endinterface : sarcr_link_if
`default_nettype wire

// *** rtl/sarcr_pkg.sv ***
// constants and types shared by the converter end and the controller end
// assumes both ends run a 100 MHz core_clk; the shift clock is made by the controller
// Summary of operation
// - power-on reset clears state, reinitialises afterwards
// - host waits 200 us after reset
// - convert_start rising edge starts a conversion
// - edges during conversion never restart it
// - busy high exactly while converting
// - host toggles convert_start only early or after
// - acquisition of next sample begins 675 ns in
// - conversion timed internally, at most 3 us
// - power down after conversion until next edge
// - last result kept while powered down
// - host idles output disabled, shift clock stopped
// - bits shift only on enabled shift clock
// - host reads result after conversion finishes
// - change on rising edge, capture on next
// - result_msb stable until first rising edge
// - normal mode: read enable high tristates output
// - result_msb appears as busy falls
// - chain mode: output always on, pin is input
// - chain data follows own 20 bits
package sarcr_pkg;
    localparam int RES_BITS      = 20;
    localparam int CLK_NS        = 10;
    localparam int POR_WAIT_NS   = 200000;
    localparam int POR_WAIT_CYC  = (POR_WAIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_MAX_NS   = 3000;
    localparam int CONV_CYC      = CONV_MAX_NS / CLK_NS;
    localparam int ACQ_START_NS  = 675;
    localparam int ACQ_CYC       = (ACQ_START_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNV_WIN_NS    = 40;
    localparam int CNV_HIGH_CYC  = CNV_WIN_NS / CLK_NS - 1;
    localparam int SCK_HALF_CYC  = 2;
    localparam int BUSY_SETTLE   = 8;
    localparam int CONV_CW       = $clog2(CONV_CYC + 1);

    typedef enum logic [1:0] {
        DEV_INIT = 2'b00,
        DEV_DOWN = 2'b01,
        DEV_CONV = 2'b10
    } sarcr_dev_state_t;

    typedef enum logic [2:0] {
        HST_POR   = 3'b000,
        HST_IDLE  = 3'b001,
        HST_CNV   = 3'b010,
        HST_WAIT  = 3'b011,
        HST_SETUP = 3'b100,
        HST_READ  = 3'b101
    } sarcr_hst_state_t;
endpackage : sarcr_pkg

// *** verification/sarcr_assertions.sv ***
// checker for the link between controller end and converter end
// assumes sck and convert_start are launched from core_clk, so one clock samples every pin
`timescale 1ns/1ns
`default_nettype none
module sarcr_assertions #(
    parameter int POR_CYC = sarcr_pkg::POR_WAIT_CYC
) (
    input wire logic core_clk,                // core clock
    input wire logic nrst,                    // reset, low active
    input wire logic convert_start,           // start request pin
    input wire logic busy,                    // conversion running
    input wire logic sck,                     // shift clock
    input wire logic sdo,                     // converter data before the tristate
    input wire logic sdo_oe_n,                // low while converter drives
    input wire logic read_enable_or_chain_in, // read enable or chain input
    input wire logic chain_mode               // strap on the converter end
);
    import sarcr_pkg::*;

    logic [15:0] busy_cnt_reg;
    logic [15:0] por_cnt_reg;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////////////
    // counters: a length of 300 cycles is too long for a repetition
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) busy_cnt_reg <= 16'h0000;
        else if (busy) busy_cnt_reg <= busy_cnt_reg + 16'h0001;
        else busy_cnt_reg <= 16'h0000;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) por_cnt_reg <= 16'h0000;
        else if (por_cnt_reg < 16'(POR_CYC)) por_cnt_reg <= por_cnt_reg + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////////
    sequence cnv_request;
        $rose(convert_start) && !busy;
    endsequence

    sequence conv_begins;
        ##[1:4] $rose(busy);
    endsequence

    AST_CONV_START: assert property (cnv_request |-> conv_begins)
        else $error("conversion did not start after convert_start rose");
    AST_BUSY_LEN: assert property ($fell(busy) |-> busy_cnt_reg == 16'(CONV_CYC))
        else $error("busy high for the wrong number of cycles");
    AST_BUSY_BOUND: assert property (busy_cnt_reg <= 16'(CONV_CYC))
        else $error("conversion ran past its maximum time");
    AST_CNV_WINDOW: assert property ($changed(convert_start) && busy |-> !$past(busy, 4))
        else $error("convert_start toggled late in a conversion");
    AST_POR_QUIET: assert property (por_cnt_reg < 16'(POR_CYC - 1) |-> !busy && !convert_start)
        else $error("activity during reinitialisation");
    AST_SCK_QUIET: assert property (busy |-> !sck)
        else $error("shift clock ran during a conversion");
    AST_SCK_ENABLED: assert property ($rose(sck) |-> !read_enable_or_chain_in)
        else $error("shift clock ran with read disabled");
    AST_OE_NORMAL: assert property (!chain_mode |-> sdo_oe_n == read_enable_or_chain_in)
        else $error("output enable does not follow read enable");
    AST_OE_CHAIN: assert property (chain_mode |-> !sdo_oe_n)
        else $error("output released in chain mode");
    AST_SDO_SHIFT: assert property ($changed(sdo) && !$past(busy) && !$past(busy, 2)
        && !$past(busy, 3) |-> $rose(sck))
        else $error("serial data changed without a shift clock rise");
endmodule : sarcr_assertions
`default_nettype wire

// *** verification/tb_sar_adc_conversion_and_serial_readout.sv ***
// self-checking bench: controller end and converter end joined by the link interface
// assumes a shortened reinitialisation wait; both ends share the 100 MHz core clock
`timescale 1ns/1ns
`default_nettype none
module tb_sar_adc_conversion_and_serial_readout;
    import sarcr_pkg::*;
    localparam int POR_SIM = 50;
    localparam int DRV     = 1;

    logic                core_clk;
    logic                nrst;
    logic                start;
    logic                chain_mode;
    logic [RES_BITS-1:0] analog_in;
    logic                ready;
    logic [RES_BITS-1:0] result;
    logic                result_valid;
    logic                powered_up;
    logic                acquiring;
    logic                init_done;
    int                  n_mismatch;
    int                  checks_done;

    sarcr_link_if sarcr_link_if_i ();
    wire busy_pin = sarcr_link_if_i.busy;
    wire rdl_pin  = sarcr_link_if_i.read_enable_or_chain_in;
    wire sck_pin  = sarcr_link_if_i.sck;
    wire sdo_pin  = sarcr_link_if_i.sdo_line;
    wire oe_n_pin = sarcr_link_if_i.sdo_oe_n;

    sarcr_dev #(.POR_CYC(POR_SIM)) sarcr_dev_i (.core_clk(core_clk), .nrst(nrst),
        .link(sarcr_link_if_i), .chain_mode(chain_mode), .analog_in(analog_in),
        .powered_up(powered_up), .acquiring(acquiring), .init_done(init_done));
    sarcr_host #(.POR_CYC(POR_SIM)) sarcr_host_i (.core_clk(core_clk), .nrst(nrst),
        .link(sarcr_link_if_i), .start(start), .ready(ready), .result(result),
        .result_valid(result_valid));
    sarcr_assertions #(.POR_CYC(POR_SIM)) sarcr_assertions_i (.core_clk(core_clk),
        .nrst(nrst), .convert_start(sarcr_link_if_i.convert_start), .busy(busy_pin),
        .sck(sck_pin), .sdo(sarcr_link_if_i.sdo), .sdo_oe_n(oe_n_pin),
        .read_enable_or_chain_in(rdl_pin), .chain_mode(chain_mode));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check_val(input logic [RES_BITS-1:0] got, input logic [RES_BITS-1:0] exp,
                             input string what);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_val

    task automatic check_cnt(input int got, input int lo, input int hi, input string what);
        checks_done++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s count %0d outside %0d..%0d", $time, what, got, lo, hi);
        end
    endtask : check_cnt

    task automatic give_verdict;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    // one-cycle start pulse, given only once the controller says it will take it
    task automatic pulse_start;
        int n;
        for (n = 0; n < 400 && ready !== 1'b1; n++) @(negedge core_clk);
        @(posedge core_clk);
        #DRV;
        start = 1'b1;
        @(posedge core_clk);
        #DRV;
        start = 1'b0;
        for (n = 0; n < 10 && busy_pin !== 1'b1; n++) @(negedge core_clk);
    endtask : pulse_start

    ////////////////////////////////////////////////////////////////////////////////
    // start held during the reinit wait must be refused; reinit length checked
    task automatic t_por;
        int n;
        @(posedge core_clk);
        #DRV;
        start = 1'b1;
        repeat (5) @(negedge core_clk);
        check_val(ready, 1'b0, "ready during reinit");
        check_val(busy_pin, 1'b0, "busy during reinit");
        check_val(init_done, 1'b0, "init_done early");
        @(posedge core_clk);
        #DRV;
        start = 1'b0;
        for (n = 6; n < 400 && init_done !== 1'b1; n++) @(negedge core_clk);
        check_cnt(n, POR_SIM - 1, POR_SIM + 2, "reinit length");
    endtask : t_por

    // one full conversion and readout, watching busy, acquisition and every serial bit
    task automatic t_convert(input logic [RES_BITS-1:0] v);
        int   n;
        int   acq_lo;
        int   nr;
        logic sck_prev;
        @(posedge core_clk);
        #DRV;
        analog_in = v;
        pulse_start();
        check_val(powered_up, 1'b1, "powered_up at start");
        n = 0;
        acq_lo = 0;
        while (busy_pin === 1'b1 && n < 400) begin
            n++;
            if (acquiring === 1'b0) acq_lo++;
            @(negedge core_clk);
        end
        check_cnt(n, CONV_CYC, CONV_CYC, "busy cycles");
        check_cnt(acq_lo, ACQ_CYC, ACQ_CYC, "acquisition delay");
        check_val(powered_up, 1'b0, "powered_up after");
        for (n = 0; n < 40 && rdl_pin !== 1'b0; n++) @(negedge core_clk);
        nr = 0;
        sck_prev = 1'b0;
        while (rdl_pin === 1'b0 && n < 400) begin
            if (sck_pin === 1'b1 && sck_prev === 1'b0) nr++;
            sck_prev = sck_pin;
            if (nr < RES_BITS) check_val(sdo_pin, v[RES_BITS-1-nr], "serial bit");
            n++;
            @(negedge core_clk);
        end
        check_cnt(nr, RES_BITS, RES_BITS, "shift clock rises");
        for (n = 0; n < 40 && result_valid !== 1'b1; n++) @(negedge core_clk);
        check_val(result_valid, 1'b1, "valid pulse");
        check_val(result, v, "result word");
        if (chain_mode) check_val(oe_n_pin, 1'b0, "output enable in chain mode");
        else check_val(sdo_pin, 1'b1, "released serial line");
    endtask : t_convert

    // reset in mid-conversion clears everything and reinitialises
    task automatic t_reset;
        int n;
        pulse_start();
        repeat (20) @(negedge core_clk);
        @(posedge core_clk);
        #DRV;
        nrst = 1'b0;
        @(negedge core_clk);
        check_val(busy_pin, 1'b0, "busy in reset");
        check_val(init_done, 1'b0, "init_done in reset");
        repeat (3) @(posedge core_clk);
        #DRV;
        nrst = 1'b1;
        for (n = 0; n < 400 && init_done !== 1'b1; n++) @(negedge core_clk);
        check_cnt(n, POR_SIM - 2, POR_SIM + 2, "second reinit length");
    endtask : t_reset

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        n_mismatch = 0;
        checks_done = 0;
        nrst = 1'b0;
        start = 1'b0;
        chain_mode = 1'b0;
        analog_in = 20'h00000;
        repeat (3) @(posedge core_clk);
        #DRV;
        nrst = 1'b1;
        t_por();
        t_convert(20'ha5c3e);
        t_convert(20'h5a3c1);
        t_convert(20'hfffff);
        t_reset();
        t_convert(20'h00001);
        @(posedge core_clk);
        #DRV;
        chain_mode = 1'b1;
        t_convert(20'h80000);
        give_verdict();
    end

    // about 2100 cycles expected; the limit leaves ample margin
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
endmodule : tb_sar_adc_conversion_and_serial_readout
`default_nettype wire
